// [core/csla_aligner.v]
// Functional notes
// - each trigger delivers red, green, blue together
// - setting is signed, -15 to +15
// - setting zero turns alignment off
// - negative setting: blue starts, delay is magnitude
// - positive setting: red starts, delay is value
// - red start: green d, blue 2d back
// - history reaches back twice the delay
`timescale 1ns/1ps
`include "csla_regs.vh"
module csla_aligner #(
    parameter PW = 8,
    parameter XW = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire in_valid,
    output wire in_ready,
    input wire [PW-1:0] in_red,
    input wire [PW-1:0] in_green,
    input wire [PW-1:0] in_blue,
    input wire in_last,
    output wire out_valid,
    input wire out_ready,
    output wire [PW-1:0] out_red,
    output wire [PW-1:0] out_green,
    output wire [PW-1:0] out_blue,
    output wire out_last
);
    localparam DW = 3 * PW;
    localparam AW = `CSLA_SLOT_W + XW;
    localparam EW = DW + 1;

    // bus slave, line tracking and input handshake state
    reg [31:0] hrdata_reg;
    reg wr_pend_reg;
    reg [5:0] wr_idx_reg;
    reg [`CSLA_SET_W-1:0] setting_reg;
    reg [`CSLA_SET_W-1:0] line_set_reg;
    reg [`CSLA_SLOT_W-1:0] slot_reg;
    reg [`CSLA_SLOT_W-1:0] held_reg;
    reg [31:0] lines_reg;
    reg [XW-1:0] x_reg;
    reg in_ready_reg;
    reg hready_reg;

    // pipeline stage between memory read and fifo
    reg p_v_reg;
    reg [DW-1:0] p_pix_reg;
    reg [`CSLA_MODE_W-1:0] p_mode_reg;
    reg p_last_reg;

    // two-entry output fifo
    reg [EW-1:0] e0_reg;
    reg [EW-1:0] e1_reg;
    reg [1:0] cnt_reg;
    reg out_valid_reg;

    wire [5:0] a_idx = haddr[`CSLA_ADDR_MSB:`CSLA_ADDR_LSB];
    wire a_take = hsel && hready && htrans[1];
    wire accept = in_valid && in_ready_reg;
    // a new setting only takes hold at a line boundary so a line is never mixed
    wire [`CSLA_SET_W-1:0] cur_set = (x_reg == {XW{1'b0}}) ? setting_reg : line_set_reg;
    wire cur_neg = cur_set[`CSLA_SET_SIGN];
    wire [`CSLA_SET_W-1:0] cur_mag = cur_neg ? (~cur_set + 5'h01) : cur_set;
    wire [`CSLA_MODE_W-1:0] cur_mode = (cur_set == `CSLA_SET_RESET) ? `CSLA_MODE_OFF :
        (cur_neg ? `CSLA_MODE_BLUE : `CSLA_MODE_RED);
    // ring of 32 slots covers 2 x 15 + 1 lines of history
    wire [`CSLA_SLOT_W-1:0] slot_d = slot_reg - cur_mag;
    wire [`CSLA_SLOT_W-1:0] slot_2d = slot_reg - {cur_mag[`CSLA_SET_W-2:0], 1'b0};
    wire [DW-1:0] in_pix = {in_red, in_green, in_blue};
    wire [DW-1:0] rd_d;
    wire [DW-1:0] rd_2d;
    wire write_ok = wr_pend_reg && (wr_idx_reg == `CSLA_OFF_SETTING) &&
        (hwdata[`CSLA_SET_W-1:0] != `CSLA_SET_FORBIDDEN);

    csla_line_mem #(.AW(AW), .DW(DW)) u_mem (
        .hclk(hclk),
        .wr_en(accept),
        .wr_addr({slot_reg, x_reg}),
        .wr_data(in_pix),
        .rd_en(accept),
        .rd_addr_a({slot_d, x_reg}),
        .rd_addr_b({slot_2d, x_reg}),
        .rd_data_a(rd_d),
        .rd_data_b(rd_2d)
    );

    // assemble the aligned pixel from the current and the two earlier lines
    reg [DW-1:0] asm_pix;
    always @* begin
        asm_pix = p_pix_reg;
        case (p_mode_reg)
            `CSLA_MODE_RED: begin
                asm_pix = {p_pix_reg[DW-1:2*PW], rd_d[2*PW-1:PW], rd_2d[PW-1:0]};
            end
            `CSLA_MODE_BLUE: begin
                asm_pix = {rd_2d[DW-1:2*PW], rd_d[2*PW-1:PW], p_pix_reg[PW-1:0]};
            end
            default: begin
                asm_pix = p_pix_reg;
            end
        endcase
    end

    wire [EW-1:0] push_word = {p_last_reg, asm_pix};
    wire push = p_v_reg;
    wire pop = out_valid_reg && out_ready;

    reg [EW-1:0] e0_next;
    reg [EW-1:0] e1_next;
    reg [1:0] cnt_next;
    always @* begin
        e0_next = e0_reg;
        e1_next = e1_reg;
        cnt_next = cnt_reg;
        if (push && pop) begin
            if (cnt_reg == `CSLA_FIFO_FULL) begin
                e0_next = e1_reg;
                e1_next = push_word;
            end else begin
                e0_next = push_word;
            end
        end else if (pop) begin
            e0_next = e1_reg;
            cnt_next = cnt_reg - 2'h1;
        end else if (push) begin
            if (cnt_reg == `CSLA_FIFO_EMPTY) begin
                e0_next = push_word;
            end else begin
                e1_next = push_word;
            end
            cnt_next = cnt_reg + 2'h1;
        end
    end

    // a word taken now lands in the fifo two edges later, so leave room for it
    wire [1:0] load_next = cnt_next + {1'b0, accept};
    wire in_ready_next = (load_next <= `CSLA_FIFO_ONE);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            e0_reg <= {EW{1'b0}};
            e1_reg <= {EW{1'b0}};
            cnt_reg <= `CSLA_FIFO_EMPTY;
            out_valid_reg <= 1'b0;
            in_ready_reg <= 1'b0;
            p_v_reg <= 1'b0;
            p_pix_reg <= {DW{1'b0}};
            p_mode_reg <= `CSLA_MODE_OFF;
            p_last_reg <= 1'b0;
        end else begin
            e0_reg <= e0_next;
            e1_reg <= e1_next;
            cnt_reg <= cnt_next;
            out_valid_reg <= (cnt_next != `CSLA_FIFO_EMPTY);
            in_ready_reg <= in_ready_next;
            p_v_reg <= accept;
            if (accept) begin
                p_pix_reg <= in_pix;
                p_mode_reg <= cur_mode;
                p_last_reg <= in_last;
            end
        end
    end

    // line position, history slot and line counters
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            x_reg <= {XW{1'b0}};
            slot_reg <= {`CSLA_SLOT_W{1'b0}};
            held_reg <= {`CSLA_SLOT_W{1'b0}};
            lines_reg <= 32'h0000_0000;
            line_set_reg <= `CSLA_SET_RESET;
        end else begin
            if (accept) begin
                if (x_reg == {XW{1'b0}}) begin
                    line_set_reg <= setting_reg;
                end
                if (in_last) begin
                    x_reg <= {XW{1'b0}};
                    slot_reg <= slot_reg + 5'h01;
                    lines_reg <= lines_reg + 32'h0000_0001;
                end else begin
                    x_reg <= x_reg + {{(XW-1){1'b0}}, 1'b1};
                end
            end
            // a setting change restarts the count of lines that are good history
            if (write_ok) begin
                held_reg <= {`CSLA_SLOT_W{1'b0}};
            end else if (accept && in_last && held_reg != `CSLA_HELD_MAX) begin
                held_reg <= held_reg + 5'h01;
            end
        end
    end

    // lines still unreliable after a start: twice the delay
    wire [`CSLA_SET_W:0] need = {setting_reg[`CSLA_SET_SIGN] ?
        (~setting_reg + 5'h01) : setting_reg, 1'b0};
    wire primed = ({1'b0, held_reg} >= need);

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (a_idx)
            `CSLA_OFF_SETTING: begin
                rd_mux = {{(32-`CSLA_SET_W){setting_reg[`CSLA_SET_SIGN]}}, setting_reg};
            end
            `CSLA_OFF_STATUS: begin
                rd_mux[`CSLA_ST_SLOT_LSB +: `CSLA_SLOT_W] = slot_reg;
                rd_mux[`CSLA_ST_HELD_LSB +: `CSLA_SLOT_W] = held_reg;
                rd_mux[`CSLA_ST_PRIMED_BIT] = primed;
            end
            `CSLA_OFF_LINES: begin
                rd_mux = lines_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // ahb-lite slave, zero wait states, always okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 6'h00;
            setting_reg <= `CSLA_SET_RESET;
            hready_reg <= 1'b0;
        end else begin
            hready_reg <= 1'b1;
            wr_pend_reg <= a_take && hwrite;
            if (a_take) begin
                wr_idx_reg <= a_idx;
            end
            if (a_take && !hwrite) begin
                hrdata_reg <= rd_mux;
            end
            if (write_ok) begin
                setting_reg <= hwdata[`CSLA_SET_W-1:0];
            end
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hready_reg;
    assign hresp = 1'b0;
    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_last = e0_reg[EW-1];
    assign out_red = e0_reg[DW-1:2*PW];
    assign out_green = e0_reg[2*PW-1:PW];
    assign out_blue = e0_reg[PW-1:0];
endmodule // csla_aligner

// [core/csla_regs.vh]
`ifndef CSLA_REGS_VH
`define CSLA_REGS_VH

// register word indices: byte address divided by four
`define CSLA_OFF_SETTING 6'h00
`define CSLA_OFF_STATUS 6'h01
`define CSLA_OFF_LINES 6'h02
`define CSLA_ADDR_LSB 2
`define CSLA_ADDR_MSB 7

// alignment setting: 5-bit two's complement
`define CSLA_SET_W 5
`define CSLA_SET_RESET 5'h00
`define CSLA_SET_FORBIDDEN 5'h10
`define CSLA_SET_SIGN 4

// status fields
`define CSLA_ST_SLOT_LSB 0
`define CSLA_ST_HELD_LSB 8
`define CSLA_ST_PRIMED_BIT 16

// history ring: 32 line slots, enough for 2 x 15 + 1 lines
`define CSLA_SLOT_W 5
`define CSLA_HELD_MAX 5'h1F

// colour order select
`define CSLA_MODE_W 2
`define CSLA_MODE_OFF 2'h0
`define CSLA_MODE_RED 2'h1
`define CSLA_MODE_BLUE 2'h2

// fifo occupancy
`define CSLA_FIFO_EMPTY 2'h0
`define CSLA_FIFO_ONE 2'h1
`define CSLA_FIFO_FULL 2'h2

`endif

// [core/csla_line_mem.v]
`timescale 1ns/1ps
// line history store: one write port, two read ports with registered data
module csla_line_mem #(
    parameter AW = 13,
    parameter DW = 24
) (
    input wire hclk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire rd_en,
    input wire [AW-1:0] rd_addr_a,
    input wire [AW-1:0] rd_addr_b,
    output reg [DW-1:0] rd_data_a,
    output reg [DW-1:0] rd_data_b
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge hclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_a <= mem[rd_addr_a];
            rd_data_b <= mem[rd_addr_b];
        end
    end
endmodule // csla_line_mem

// [bench/csla_aligner_asserts.sv]
`timescale 1ns/1ps
module csla_aligner_asserts #(
    parameter PW = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire in_valid,
    input wire in_ready,
    input wire in_last,
    input wire out_valid,
    input wire out_ready,
    input wire [PW-1:0] out_red,
    input wire [PW-1:0] out_green,
    input wire [PW-1:0] out_blue,
    input wire out_last
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire rd_ap = hsel && hready && htrans[1] && !hwrite;
    wire acc = in_valid && in_ready;
    reg wr_pend;
    reg [4:0] set_q;
    reg [31:0] lines_q;
    reg [2:0] held;
    wire [31:0] set_ext = {{27{set_q[4]}}, set_q};
    // shadow of the setting; the one forbidden value, 5'h10 (-16), is never taken
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            set_q <= 5'h00;
            lines_q <= 32'h0;
            held <= 3'h0;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite && haddr[7:2] == 6'h00;
            if (wr_pend && hwdata[4:0] != 5'h10)
                set_q <= hwdata[4:0];
            if (acc && in_last)
                lines_q <= lines_q + 32'h1;
            held <= held + {2'h0, acc} - {2'h0, out_valid && out_ready};
        end
    end
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("not okay");
    chk_ready_up: assert property ($past(hresetn) |-> hreadyout)
        else $error("not ready");
    chk_set_read: assert property (rd_ap && haddr[7:2] == 6'h00 |=>
        hrdata == $past(set_ext)) else $error("bad setting");
    chk_line_count: assert property (rd_ap && haddr[7:2] == 6'h02 |=>
        hrdata == $past(lines_q)) else $error("bad count");
    chk_unmapped_zero: assert property (rd_ap && haddr[7:2] > 6'h02 |=> hrdata == 32'h0)
        else $error("unmapped");
    chk_out_hold: assert property (out_valid && !out_ready |=> out_valid &&
        $stable({out_red, out_green, out_blue, out_last})) else $error("dropped");
    chk_in_out: assert property (acc |-> ##[2:60] out_valid)
        else $error("lost pixel");
    chk_buffer_bound: assert property (held <= 3'h2 && (out_valid -> held != 3'h0))
        else $error("buffer count");
endmodule // csla_aligner_asserts

// [bench/csla_sensor_model.sv]
`timescale 1ns/1ps
module csla_sensor_model #(
    parameter PW = 8
) (
    input wire hclk,
    input wire in_ready,
    output reg in_valid,
    output reg [PW-1:0] in_red,
    output reg [PW-1:0] in_green,
    output reg [PW-1:0] in_blue,
    output reg in_last
);
    initial begin
        {in_valid, in_last, in_red, in_green, in_blue} = 0;
    end
    // one trigger exposes all three lines, so one index feeds every colour
    task send_line(input [PW-1:0] base, input integer len);
        integer x;
        begin
            for (x = 0; x < len; x = x + 1) begin
                in_valid <= 1'b1;
                in_red <= base + x;
                in_green <= base + x + 8'h55;
                in_blue <= base + x + 8'hAA;
                in_last <= x == len - 1;
                @(posedge hclk);
                while (!in_ready)
                    @(posedge hclk);
            end
            // idle lines show garbage, not the last pixel
            // a fixed one-cycle gap between lines; in_ready stalls still vary the line period
            in_valid <= 1'b0;
            in_red <= ~in_red;
            in_green <= ~in_green;
            in_blue <= ~in_blue;
            @(posedge hclk);
        end
    endtask
endmodule // csla_sensor_model

// [bench/csla_aligner_tb.sv]
`timescale 1ns/1ps
bind csla_aligner csla_aligner_asserts #(.PW(PW)) chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_ready(in_ready),
    .in_last(in_last), .out_valid(out_valid), .out_ready(out_ready), .out_red(out_red),
    .out_green(out_green), .out_blue(out_blue), .out_last(out_last)
);
module csla_aligner_tb;
    reg hclk, hresetn, hsel, hwrite;
    reg out_ready = 1'b0;
    reg refused = 1'b0;
    reg [1:0] htrans;
    reg [31:0] haddr, hwdata, rd;
    wire [2:0] hsize = 3'h2;
    wire hreadyout, hresp, in_valid, in_ready, in_last, out_valid, out_last;
    wire hready = hreadyout;
    wire [31:0] hrdata;
    wire [7:0] in_red, in_green, in_blue, out_red, out_green, out_blue;
    integer fail_count, n_checks, nin, r, k, d, t;
    integer cyc = 0, nout = 0, xo = 0;
    reg [19:0] rows = {5'h0F, 5'h1A, 5'h08, 5'h00};
    reg [4:0] ln_set [0:255];
    reg ln_ok [0:255];
    csla_aligner dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_ready(in_ready),
        .in_red(in_red), .in_green(in_green), .in_blue(in_blue), .in_last(in_last),
        .out_valid(out_valid), .out_ready(out_ready), .out_red(out_red),
        .out_green(out_green), .out_blue(out_blue), .out_last(out_last)
    );
    csla_sensor_model sensor (
        .hclk(hclk), .in_ready(in_ready), .in_valid(in_valid), .in_red(in_red),
        .in_green(in_green), .in_blue(in_blue), .in_last(in_last)
    );
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task check(input [31:0] seen, input [31:0] want, input [63:0] what);
        begin
            n_checks = n_checks + 1;
            if (seen !== want) begin
                fail_count = fail_count + 1;
                $display("wrong value %0s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (fail_count == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task ahb(input w, input [31:0] a, input [31:0] wd, output [31:0] rdv);
        begin
            haddr <= a;
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge hclk);
            while (!hreadyout)
                @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge hclk);
            while (!hreadyout)
                @(posedge hclk);
            rdv = hrdata;
        end
    endtask
    function [31:0] expect_pix(input integer l, input integer x, input [4:0] s);
        integer m, lr, lb;
        reg [7:0] vr, vg, vb;
        begin
            m = s[4] ? 32 - s : s;
            lr = s[4] ? l - 2 * m : l;
            lb = s[4] ? l : l - 2 * m;
            vr = lr * 4 + x;
            vg = (l - m) * 4 + x + 85;
            vb = lb * 4 + x + 170;
            expect_pix = {8'h0, vr, vg, vb};
        end
    endfunction
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        // long stalls fill the two-entry buffer so the input must be refused
        out_ready <= cyc % 64 >= 12 && cyc % 3 != 0;
        if (hresetn && in_valid && !in_ready)
            refused <= 1'b1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            tally_and_finish;
        end
        if (hresetn && out_valid && out_ready) begin
            if (ln_ok[nout])
                check({8'h0, out_red, out_green, out_blue}, expect_pix(nout, xo, ln_set[nout]),
                    "pixel");
            check({31'h0, out_last}, {31'h0, xo == 3}, "last");
            xo = out_last ? 0 : xo + 1;
            nout = out_last ? nout + 1 : nout;
        end
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
        {fail_count, n_checks, nin} = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd, 32'h0, "setting");
        ahb(1'b0, 32'h3C, 32'h0, rd);
        check(rd, 32'h0, "unmapped");
        for (r = 0; r < 4; r = r + 1) begin
            ahb(1'b1, 32'h0, {27'h0, rows[r*5 +: 5]}, rd);
            ahb(1'b0, 32'h0, 32'h0, rd);
            check(rd, {{27{rows[r*5+4]}}, rows[r*5 +: 5]}, "setting");
            d = rows[r*5+4] ? 32 - rows[r*5 +: 5] : rows[r*5 +: 5];
            for (k = 0; k < 2 * d + 3; k = k + 1) begin
                ln_set[nin] = rows[r*5 +: 5];
                ln_ok[nin] = k >= 2 * d;
                sensor.send_line(nin * 4, 4);
                nin = nin + 1;
            end
        end
        for (t = 0; t < 400 && nout != nin; t = t + 1)
            @(posedge hclk);
        check(nout, nin, "lines");
        check({31'h0, refused}, 32'h1, "refuse");
        ahb(1'b0, 32'h8, 32'h0, rd);
        check(rd, nin, "count");
        ahb(1'b1, 32'h0, 32'h0F, rd);
        ahb(1'b0, 32'h4, 32'h0, rd);
        check(rd & 32'h1FF00, 32'h0, "status");
        ahb(1'b1, 32'h0, 32'h10, rd);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd, 32'hF, "setting");
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd, 32'h0, "setting");
        tally_and_finish;
    end
endmodule // csla_aligner_tb
